// ==== dofs_top.sv ====
// Digital output function selector with an AXI4-Lite register slave.
// Assumes condition flags synchronous to clk; detectors live elsewhere.
//
// Functional notes
// - Three outputs, two relays and one open collector, each with own code.
// - Several outputs may share one code and then follow one condition; for codes 23 to 25 each follows its own virtual bit.
// - Code 0 holds the output OFF always.
// - Code 1 ON while running with non-zero output frequency.
// - Code 2 ON while producing frequency in forward direction.
// - Code 3 ON while producing frequency in reverse direction.
// - Code 4 ON while producing frequency in jog operation.
// - Code 5 ON while a drive fault is present.
// - Codes 6, 7, 8 follow level detectors one, two and frequency reached.
// - Code 9 ON when output and reference frequency both zero.
// - Code 10 ON when running frequency reached upper limit.
// - Code 11 ON when running frequency reached lower limit.
// - Code 12 ON when both powers up, no protection, ready to run.
// - Code 13 ON during motor pre-excitation.
// - Code 14 follows the overload pre-alarm flag.
// - Code 15 follows the underload pre-alarm flag.
// - Code 16 signals sequencer stage completed.
// - Code 17 signals sequencer cycle completed.
// - Codes 18, 19, 20, 22 follow count, count, external fault, run time flags.
// - Code 23 follows the Modbus virtual bit.
// - Code 24 follows the PROFIBUS or CANopen virtual bit.
// - Code 25 follows the Ethernet virtual bit.
`timescale 1ns/1ps
module dofs_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic drive_running,
   input wire logic out_freq_nonzero,
   input wire logic dir_reverse,
   input wire logic jog_active,
   input wire logic fault_active,
   input wire logic freq_level_detect_one,
   input wire logic freq_level_detect_two,
   input wire logic freq_reached,
   input wire logic ref_freq_zero,
   input wire logic upper_limit_reached,
   input wire logic lower_limit_reached,
   input wire logic main_power_ok,
   input wire logic ctrl_power_ok,
   input wire logic protection_active,
   input wire logic ready_to_run,
   input wire logic pre_exciting,
   input wire logic overload_prealarm,
   input wire logic underload_prealarm,
   input wire logic seq_stage_done,
   input wire logic seq_cycle_done,
   input wire logic set_count_reached,
   input wire logic designated_count_reached,
   input wire logic ext_fault_active,
   input wire logic run_time_reached,
   output logic y1_out,
   output logic ro1_out,
   output logic ro2_out,
   input wire logic [dofs_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [dofs_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [dofs_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [dofs_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // Word decode shared by both channels
   function automatic logic [2:0] decode(input logic [dofs_pkg::ADDR_W-1:0] a);
      logic [7:0] w;
      w = {a[7:2], 2'b00};
      case (w)
         dofs_pkg::OFS_Y1_CODE: decode = dofs_pkg::IDX_Y1;
         dofs_pkg::OFS_RO1_CODE: decode = dofs_pkg::IDX_RO1;
         dofs_pkg::OFS_RO2_CODE: decode = dofs_pkg::IDX_RO2;
         dofs_pkg::OFS_VIRT_MODBUS: decode = dofs_pkg::IDX_MODBUS;
         dofs_pkg::OFS_VIRT_FIELDBUS: decode = dofs_pkg::IDX_FIELDBUS;
         dofs_pkg::OFS_VIRT_ETHERNET: decode = dofs_pkg::IDX_ETHERNET;
         dofs_pkg::OFS_OUT_STATUS: decode = dofs_pkg::IDX_STATUS;
         default: decode = dofs_pkg::IDX_NONE;
      endcase
   endfunction

   // Per-output condition table: common conditions plus its own virtual bits
   function automatic logic [dofs_pkg::FC_TABLE-1:0] out_table(
      input logic [dofs_pkg::FC_TABLE-1:0] common,
      input logic mb,
      input logic fb,
      input logic eth);
      logic [dofs_pkg::FC_TABLE-1:0] t;
      t = common;
      t[dofs_pkg::FC_VIRT_MODBUS] = mb;
      t[dofs_pkg::FC_VIRT_FIELDBUS] = fb;
      t[dofs_pkg::FC_VIRT_ETHERNET] = eth;
      out_table = t;
   endfunction

   // Codes beyond the table select nothing
   function automatic logic select(input logic [dofs_pkg::CODE_W-1:0] code,
      input logic [dofs_pkg::FC_TABLE-1:0] t);
      if (code < 8'(dofs_pkg::FC_TABLE)) begin
         select = t[code[4:0]];
      end else begin
         select = 1'b0;
      end
   endfunction

   logic [7:0] y1_code_reg;
   logic [7:0] ro1_code_reg;
   logic [7:0] ro2_code_reg;
   logic [2:0] virt_mb_reg;
   logic [2:0] virt_fb_reg;
   logic [2:0] virt_eth_reg;
   logic [2:0] out_reg;
   logic [2:0] out_next;
   logic [dofs_pkg::FC_TABLE-1:0] cond;
   logic [dofs_pkg::ADDR_W-1:0] awaddr_reg;
   logic [7:0] wdata_reg;
   logic wstrb0_reg;
   logic aw_have_reg;
   logic w_have_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;

   // Condition table indexed by function code
   wire freq_out = drive_running & out_freq_nonzero;
   always_comb begin
      cond = '0;
      cond[dofs_pkg::FC_RUNNING] = freq_out;
      cond[dofs_pkg::FC_FORWARD] = freq_out & ~dir_reverse;
      cond[dofs_pkg::FC_REVERSE] = freq_out & dir_reverse;
      cond[dofs_pkg::FC_JOG] = freq_out & jog_active;
      cond[dofs_pkg::FC_FAULT] = fault_active;
      cond[dofs_pkg::FC_FDT_ONE] = freq_level_detect_one;
      cond[dofs_pkg::FC_FDT_TWO] = freq_level_detect_two;
      cond[dofs_pkg::FC_FREQ_REACHED] = freq_reached;
      cond[dofs_pkg::FC_ZERO_SPEED] = ~out_freq_nonzero & ref_freq_zero;
      cond[dofs_pkg::FC_UPPER_LIMIT] = upper_limit_reached;
      cond[dofs_pkg::FC_LOWER_LIMIT] = lower_limit_reached;
      cond[dofs_pkg::FC_READY] = main_power_ok & ctrl_power_ok & ~protection_active
         & ready_to_run;
      cond[dofs_pkg::FC_PRE_EXCITE] = pre_exciting;
      cond[dofs_pkg::FC_OVERLOAD] = overload_prealarm;
      cond[dofs_pkg::FC_UNDERLOAD] = underload_prealarm;
      cond[dofs_pkg::FC_SEQ_STAGE] = seq_stage_done;
      cond[dofs_pkg::FC_SEQ_CYCLE] = seq_cycle_done;
      cond[dofs_pkg::FC_SET_COUNT] = set_count_reached;
      cond[dofs_pkg::FC_DESIG_COUNT] = designated_count_reached;
      cond[dofs_pkg::FC_EXT_FAULT] = ext_fault_active;
      cond[dofs_pkg::FC_RESERVED_21] = 1'b0;
      cond[dofs_pkg::FC_RUN_TIME] = run_time_reached;
   end

   // One selector per terminal
   assign out_next[dofs_pkg::POS_Y1] = select(y1_code_reg, out_table(cond,
      virt_mb_reg[dofs_pkg::POS_Y1], virt_fb_reg[dofs_pkg::POS_Y1],
      virt_eth_reg[dofs_pkg::POS_Y1]));
   assign out_next[dofs_pkg::POS_RO1] = select(ro1_code_reg, out_table(cond,
      virt_mb_reg[dofs_pkg::POS_RO1], virt_fb_reg[dofs_pkg::POS_RO1],
      virt_eth_reg[dofs_pkg::POS_RO1]));
   assign out_next[dofs_pkg::POS_RO2] = select(ro2_code_reg, out_table(cond,
      virt_mb_reg[dofs_pkg::POS_RO2], virt_fb_reg[dofs_pkg::POS_RO2],
      virt_eth_reg[dofs_pkg::POS_RO2]));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_reg <= 3'h0;
      end else begin
         out_reg <= out_next;
      end
   end

   assign y1_out = out_reg[dofs_pkg::POS_Y1];
   assign ro1_out = out_reg[dofs_pkg::POS_RO1];
   assign ro2_out = out_reg[dofs_pkg::POS_RO2];

   // Write channel: address and data taken in either order
   wire aw_take = s_axi_awvalid & awready_reg;
   wire w_take = s_axi_wvalid & wready_reg;
   wire aw_avail = aw_have_reg | aw_take;
   wire w_avail = w_have_reg | w_take;
   wire do_write = aw_avail & w_avail;
   wire [dofs_pkg::ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : awaddr_reg;
   wire [7:0] wr_byte = w_take ? s_axi_wdata[7:0] : wdata_reg;
   wire wr_lane = w_take ? s_axi_wstrb[0] : wstrb0_reg;
   wire [2:0] wr_idx = decode(wr_addr);
   wire wr_en = do_write & wr_lane;
   wire aw_have_next = aw_avail & ~do_write;
   wire w_have_next = w_avail & ~do_write;
   wire bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= dofs_pkg::RESP_OKAY;
         awaddr_reg <= '0;
         wdata_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
      end else begin
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         awready_reg <= ~aw_have_next & ~bvalid_next;
         wready_reg <= ~w_have_next & ~bvalid_next;
         bvalid_reg <= bvalid_next;
         awaddr_reg <= wr_addr;
         wdata_reg <= wr_byte;
         wstrb0_reg <= wr_lane;
         if (do_write) begin
            bresp_reg <= (wr_idx == dofs_pkg::IDX_NONE) ? dofs_pkg::RESP_SLVERR
               : dofs_pkg::RESP_OKAY;
         end
      end
   end

   // Configuration registers; status is read only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         y1_code_reg <= dofs_pkg::RST_Y1_CODE;
         ro1_code_reg <= dofs_pkg::RST_RO1_CODE;
         ro2_code_reg <= dofs_pkg::RST_RO2_CODE;
         virt_mb_reg <= dofs_pkg::RST_VIRT;
         virt_fb_reg <= dofs_pkg::RST_VIRT;
         virt_eth_reg <= dofs_pkg::RST_VIRT;
      end else if (wr_en) begin
         case (wr_idx)
            dofs_pkg::IDX_Y1: y1_code_reg <= wr_byte;
            dofs_pkg::IDX_RO1: ro1_code_reg <= wr_byte;
            dofs_pkg::IDX_RO2: ro2_code_reg <= wr_byte;
            dofs_pkg::IDX_MODBUS: virt_mb_reg <= wr_byte[2:0];
            dofs_pkg::IDX_FIELDBUS: virt_fb_reg <= wr_byte[2:0];
            dofs_pkg::IDX_ETHERNET: virt_eth_reg <= wr_byte[2:0];
            default: ;
         endcase
      end
   end

   // Read channel
   wire ar_take = s_axi_arvalid & arready_reg;
   wire [2:0] rd_idx = decode(s_axi_araddr);
   wire rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
   logic [31:0] rd_word;
   always_comb begin
      case (rd_idx)
         dofs_pkg::IDX_Y1: rd_word = {24'h000000, y1_code_reg};
         dofs_pkg::IDX_RO1: rd_word = {24'h000000, ro1_code_reg};
         dofs_pkg::IDX_RO2: rd_word = {24'h000000, ro2_code_reg};
         dofs_pkg::IDX_MODBUS: rd_word = {29'h0, virt_mb_reg};
         dofs_pkg::IDX_FIELDBUS: rd_word = {29'h0, virt_fb_reg};
         dofs_pkg::IDX_ETHERNET: rd_word = {29'h0, virt_eth_reg};
         dofs_pkg::IDX_STATUS: rd_word = {29'h0, out_reg};
         default: rd_word = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= dofs_pkg::RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end else begin
         arready_reg <= ~rvalid_next;
         rvalid_reg <= rvalid_next;
         if (ar_take) begin
            rdata_reg <= rd_word;
            rresp_reg <= (rd_idx == dofs_pkg::IDX_NONE) ? dofs_pkg::RESP_SLVERR
               : dofs_pkg::RESP_OKAY;
         end
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_code_zero_off: assert property (y1_code_reg == 8'h00 |=> !y1_out)
      else $error("Y1 on with code 0");
   a_run_follow: assert property (y1_code_reg == 8'h01 |=>
      y1_out == $past(drive_running & out_freq_nonzero))
      else $error("Y1 does not follow running");
   a_fwd_follow: assert property (ro1_code_reg == 8'h02 |=>
      ro1_out == $past(freq_out & ~dir_reverse))
      else $error("RO1 does not follow forward");
   a_rev_follow: assert property (ro2_code_reg == 8'h03 |=>
      ro2_out == $past(freq_out & dir_reverse))
      else $error("RO2 does not follow reverse");
   a_jog_follow: assert property (y1_code_reg == 8'h04 |=>
      y1_out == $past(freq_out & jog_active))
      else $error("Y1 does not follow jog");
   a_fault_follow: assert property (ro1_code_reg == 8'h05 |=>
      ro1_out == $past(fault_active))
      else $error("RO1 does not follow fault");
   a_level_one: assert property (ro2_code_reg == 8'h06 |=>
      ro2_out == $past(freq_level_detect_one))
      else $error("RO2 does not follow level one");
   a_level_two: assert property (ro1_code_reg == 8'h07 |=>
      ro1_out == $past(freq_level_detect_two))
      else $error("RO1 does not follow level two");
   a_zero_speed: assert property (ro2_code_reg == 8'h09 |=>
      ro2_out == $past(~out_freq_nonzero & ref_freq_zero))
      else $error("RO2 wrong for zero speed");
   a_upper_limit: assert property (ro2_code_reg == 8'h0A |=>
      ro2_out == $past(upper_limit_reached))
      else $error("RO2 does not follow upper limit");
   a_lower_limit: assert property (y1_code_reg == 8'h0B |=>
      y1_out == $past(lower_limit_reached))
      else $error("Y1 does not follow lower limit");
   a_ready_run: assert property (y1_code_reg == 8'h0C |=> y1_out == $past(main_power_ok
      & ctrl_power_ok & ~protection_active & ready_to_run))
      else $error("Y1 wrong for ready");
   a_pre_excite: assert property (ro1_code_reg == 8'h0D |=>
      ro1_out == $past(pre_exciting))
      else $error("RO1 does not follow pre-excitation");
   a_overload_flag: assert property (y1_code_reg == 8'h0E |=>
      y1_out == $past(overload_prealarm))
      else $error("Y1 does not follow overload flag");
   a_underload_flag: assert property (ro2_code_reg == 8'h0F |=>
      ro2_out == $past(underload_prealarm))
      else $error("RO2 does not follow underload flag");
   a_seq_stage: assert property (ro1_code_reg == 8'h10 |=>
      ro1_out == $past(seq_stage_done))
      else $error("RO1 does not follow stage done");
   a_seq_cycle: assert property (ro2_code_reg == 8'h11 |=>
      ro2_out == $past(seq_cycle_done))
      else $error("RO2 does not follow cycle done");
   a_count_flag: assert property (y1_code_reg == 8'h12 |=>
      y1_out == $past(set_count_reached))
      else $error("Y1 does not follow set count");
   a_modbus_bit: assert property (ro1_code_reg == 8'h17 |=>
      ro1_out == $past(virt_mb_reg[1]))
      else $error("RO1 does not follow Modbus bit");
   a_fieldbus_bit: assert property (ro2_code_reg == 8'h18 |=>
      ro2_out == $past(virt_fb_reg[2]))
      else $error("RO2 does not follow fieldbus bit");
   a_ethernet_bit: assert property (y1_code_reg == 8'h19 |=>
      y1_out == $past(virt_eth_reg[0]))
      else $error("Y1 does not follow Ethernet bit");
   a_shared_code: assert property (y1_code_reg == ro1_code_reg
      && virt_mb_reg[0] == virt_mb_reg[1] && virt_fb_reg[0] == virt_fb_reg[1]
      && virt_eth_reg[0] == virt_eth_reg[1] |=> y1_out == ro1_out)
      else $error("Shared code gives different outputs");
   a_reserved_off: assert property (ro1_code_reg == 8'h15 || ro1_code_reg > 8'h19
      && ro1_code_reg < 8'h20 || ro1_code_reg >= 8'h20 |=> !ro1_out)
      else $error("RO1 on with reserved code");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped");

   c_write_done: cover property (s_axi_bvalid && s_axi_bready);
   c_read_done: cover property (s_axi_rvalid && s_axi_rready);
   c_relay_on: cover property (!ro1_out ##1 ro1_out);
   c_bad_addr: cover property (s_axi_rvalid && s_axi_rresp == dofs_pkg::RESP_SLVERR);

endmodule // dofs_top

// ==== dofs_pkg.sv ====
// Constants for the digital output function selector.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing.
package dofs_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CODE_W = 8;
   localparam int NUM_OUT = 3;
   // Register byte offsets
   localparam logic [7:0] OFS_Y1_CODE = 8'h00;
   localparam logic [7:0] OFS_RO1_CODE = 8'h04;
   localparam logic [7:0] OFS_RO2_CODE = 8'h08;
   localparam logic [7:0] OFS_VIRT_MODBUS = 8'h0C;
   localparam logic [7:0] OFS_VIRT_FIELDBUS = 8'h10;
   localparam logic [7:0] OFS_VIRT_ETHERNET = 8'h14;
   localparam logic [7:0] OFS_OUT_STATUS = 8'h18;
   // Register indices returned by the address decoder
   localparam logic [2:0] IDX_Y1 = 3'h0;
   localparam logic [2:0] IDX_RO1 = 3'h1;
   localparam logic [2:0] IDX_RO2 = 3'h2;
   localparam logic [2:0] IDX_MODBUS = 3'h3;
   localparam logic [2:0] IDX_FIELDBUS = 3'h4;
   localparam logic [2:0] IDX_ETHERNET = 3'h5;
   localparam logic [2:0] IDX_STATUS = 3'h6;
   localparam logic [2:0] IDX_NONE = 3'h7;
   // Reset values
   localparam logic [7:0] RST_Y1_CODE = 8'h00;
   localparam logic [7:0] RST_RO1_CODE = 8'h01;
   localparam logic [7:0] RST_RO2_CODE = 8'h00;
   localparam logic [2:0] RST_VIRT = 3'h0;
   // Output bit positions in the status and virtual registers
   localparam int POS_Y1 = 0;
   localparam int POS_RO1 = 1;
   localparam int POS_RO2 = 2;
   // Function codes
   localparam int FC_INVALID = 0;
   localparam int FC_RUNNING = 1;
   localparam int FC_FORWARD = 2;
   localparam int FC_REVERSE = 3;
   localparam int FC_JOG = 4;
   localparam int FC_FAULT = 5;
   localparam int FC_FDT_ONE = 6;
   localparam int FC_FDT_TWO = 7;
   localparam int FC_FREQ_REACHED = 8;
   localparam int FC_ZERO_SPEED = 9;
   localparam int FC_UPPER_LIMIT = 10;
   localparam int FC_LOWER_LIMIT = 11;
   localparam int FC_READY = 12;
   localparam int FC_PRE_EXCITE = 13;
   localparam int FC_OVERLOAD = 14;
   localparam int FC_UNDERLOAD = 15;
   localparam int FC_SEQ_STAGE = 16;
   localparam int FC_SEQ_CYCLE = 17;
   localparam int FC_SET_COUNT = 18;
   localparam int FC_DESIG_COUNT = 19;
   localparam int FC_EXT_FAULT = 20;
   localparam int FC_RESERVED_21 = 21;
   localparam int FC_RUN_TIME = 22;
   localparam int FC_VIRT_MODBUS = 23;
   localparam int FC_VIRT_FIELDBUS = 24;
   localparam int FC_VIRT_ETHERNET = 25;
   localparam int FC_TABLE = 32;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== dofs_out_stage.sv ====
// Behavioural model of the three terminal driver stages.
// Assumes level outputs from the selector; the open collector has a pull-up.
`timescale 1ns/1ps
module dofs_out_stage (
   input wire logic y1_out,
   input wire logic ro1_out,
   input wire logic ro2_out,
   output logic y1_term_n,
   output logic ro1_closed,
   output logic ro2_closed
);
   // Transistor sinks when ON, pull-up otherwise
   assign y1_term_n = y1_out ? 1'b0 : 1'b1;
   // Relay contacts close while energised
   assign ro1_closed = ro1_out;
   assign ro2_closed = ro2_out;
endmodule // dofs_out_stage

// ==== tb_digital_output_function_select.sv ====
// Self-checking bench for the output function selector.
// Assumes the AXI4-Lite timing and register map of the selector top.
`timescale 1ns/1ps
module tb_digital_output_function_select;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [23:0] cond = 24'h000000;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, y1, ro1, ro2;
   logic y1_term_n, ro1_closed, ro2_closed;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata;
   logic [31:0] lfsr = 32'h9707459B;
   logic [2:0] vmb = 3'h0, vfb = 3'h0, veth = 3'h0;
   logic [7:0] code [3];
   logic [2:0] exp_st;
   int miscompares = 0;
   int cmp_count = 0;

   always #10 clk = ~clk;

   dofs_top i_dut (.clk(clk), .rst_n(rst_n),
      .drive_running(cond[0]), .out_freq_nonzero(cond[1]), .dir_reverse(cond[2]),
      .jog_active(cond[3]), .fault_active(cond[4]), .freq_level_detect_one(cond[5]),
      .freq_level_detect_two(cond[6]), .freq_reached(cond[7]), .ref_freq_zero(cond[8]),
      .upper_limit_reached(cond[9]), .lower_limit_reached(cond[10]),
      .main_power_ok(cond[11]), .ctrl_power_ok(cond[12]), .protection_active(cond[13]),
      .ready_to_run(cond[14]), .pre_exciting(cond[15]), .overload_prealarm(cond[16]),
      .underload_prealarm(cond[17]), .seq_stage_done(cond[18]), .seq_cycle_done(cond[19]),
      .set_count_reached(cond[20]), .designated_count_reached(cond[21]),
      .ext_fault_active(cond[22]), .run_time_reached(cond[23]),
      .y1_out(y1), .ro1_out(ro1), .ro2_out(ro2),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   dofs_out_stage i_stage (.y1_out(y1), .ro1_out(ro1), .ro2_out(ro2),
      .y1_term_n(y1_term_n), .ro1_closed(ro1_closed), .ro2_closed(ro2_closed));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
   endfunction

   function automatic logic exp_out(input logic [7:0] f, input logic [23:0] c, input int p);
      case (f)
         8'h01: return c[0] & c[1];
         8'h02: return c[0] & c[1] & ~c[2];
         8'h03: return c[0] & c[1] & c[2];
         8'h04: return c[0] & c[1] & c[3];
         8'h05: return c[4];
         8'h06, 8'h07, 8'h08: return c[f - 8'h01];
         8'h09: return ~c[1] & c[8];
         8'h0A, 8'h0B: return c[f - 8'h01];
         8'h0C: return c[11] & c[12] & ~c[13] & c[14];
         8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11: return c[f + 8'h02];
         8'h12, 8'h13, 8'h14: return c[f + 8'h02];
         8'h16: return c[23];
         8'h17: return vmb[p];
         8'h18: return vfb[p];
         8'h19: return veth[p];
         default: return 1'b0;
      endcase
   endfunction

   task automatic chk_bit(input logic got, input logic exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %b expected %b", $time, msg, got, exp);
      end
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic hang(input string msg);
      miscompares++;
      $display("[FAIL] %0t %s timed out", $time, msg);
      complete_run();
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      bit aw_done = 0;
      bit w_done = 0;
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50 && !(aw_done && w_done); n++) begin
         @(posedge clk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1;
            wvalid <= 1'b0;
         end
      end
      if (!(aw_done && w_done)) hang("write address or data");
      for (n = 0; n < 50 && bvalid !== 1'b1; n++) @(posedge clk);
      if (n == 50) hang("write response");
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arready === 1'b1) break;
      end
      if (n == 50) hang("read address");
      arvalid <= 1'b0;
      for (n = 0; n < 50 && rvalid !== 1'b1; n++) @(posedge clk);
      if (n == 50) hang("read data");
      rready <= 1'b0;
      chk_word(rdata, exp, "read data");
      chk_word({30'h0, rresp}, {30'h0, er}, "read response");
   endtask

   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      axi_write(a, d, 4'hF);
      chk_word({30'h0, resp}, {30'h0, er}, "write response");
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) rd_chk(8'(i * 4), (i == 1) ? 32'h1 : 32'h0, 2'h0);
      @(posedge clk);
      cond <= 24'h000003;
      @(posedge clk);
      #1;
      chk_bit(ro1_closed, 1'b1, "default relay one running");
      chk_bit(y1_term_n, 1'b1, "default open collector off");
      rd_chk(8'h1C, 32'h0, dofs_pkg::RESP_SLVERR);
      wr_ok(8'h1C, 32'h5, dofs_pkg::RESP_SLVERR);
      wr_ok(dofs_pkg::OFS_OUT_STATUS, 32'h7, dofs_pkg::RESP_OKAY);
      axi_write(dofs_pkg::OFS_Y1_CODE, 32'h5, 4'h0);
      rd_chk(dofs_pkg::OFS_Y1_CODE, 32'h0, dofs_pkg::RESP_OKAY);
      for (int k = 0; k < 29; k++) begin
         code[0] = (k < 28) ? 8'(k) : 8'hFF;
         code[1] = code[0];
         code[2] = 8'((k + 11) % 26);
         lfsr = lfsr_next(lfsr);
         {vmb, vfb, veth} = lfsr[8:0];
         for (int o = 0; o < 3; o++) wr_ok(8'(o * 4), {24'h0, code[o]}, dofs_pkg::RESP_OKAY);
         wr_ok(dofs_pkg::OFS_VIRT_MODBUS, {29'h0, vmb}, dofs_pkg::RESP_OKAY);
         wr_ok(dofs_pkg::OFS_VIRT_FIELDBUS, {29'h0, vfb}, dofs_pkg::RESP_OKAY);
         wr_ok(dofs_pkg::OFS_VIRT_ETHERNET, {29'h0, veth}, dofs_pkg::RESP_OKAY);
         rd_chk(dofs_pkg::OFS_RO2_CODE, {24'h0, code[2]}, dofs_pkg::RESP_OKAY);
         for (int j = 0; j < 6; j++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk);
            cond <= (j == 0) ? 24'hFFDFFF : (j == 1) ? 24'h000100 : lfsr[23:0];
            @(posedge clk);
            #1;
            for (int o = 0; o < 3; o++) exp_st[o] = exp_out(code[o], cond, o);
            chk_bit(~y1_term_n, exp_st[0], "open collector output");
            chk_bit(ro1_closed, exp_st[1], "relay one output");
            chk_bit(ro2_closed, exp_st[2], "relay two output");
         end
         rd_chk(dofs_pkg::OFS_OUT_STATUS, {29'h0, exp_st}, dofs_pkg::RESP_OKAY);
      end
      complete_run();
   end
endmodule // tb_digital_output_function_select
